// [pkg/rsc_pkg.sv]
// Constants and types shared by the reset source controller
package rsc_pkg;

   // ========================================================================
   // Timing
   // ========================================================================
   localparam int CLK_PERIOD_NS = 10;
   // Power-on release delay, 0.3 ms, longest time: rounded down
   localparam int POR_DELAY_US = 300;
   localparam int POR_DELAY_CYC = (POR_DELAY_US * 1000) / CLK_PERIOD_NS;
   // Missing clock timeout, least time: rounded up
   localparam int CLK_LOSS_TIMEOUT_US = 100;
   localparam int CLK_LOSS_TIMEOUT_CYC =
      (CLK_LOSS_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Shortest stay in reset for pulse sources
   localparam int HOLD_MIN_CYC = 4;
   localparam int CNT_W = 16;

   // ========================================================================
   // Register map
   // ========================================================================
   localparam logic [7:0] REG_RESET_SOURCE_ADDR = 8'hef;
   localparam logic [7:0] REG_SUPPLY_MON_ADDR = 8'hfe;
   localparam int BIT_PIN = 0;
   localparam int BIT_POR = 1;
   localparam int BIT_CLK_LOSS = 2;
   localparam int BIT_WDOG = 3;
   localparam int BIT_SW = 4;
   localparam int BIT_CMP = 5;
   localparam int BIT_MON_EN = 7;
   // Internal only: supply monitor cause, never a flag
   localparam int SRC_MON = 6;
   localparam int NUM_FLAGS = 6;
   localparam int NUM_SRC = 7;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // ========================================================================
   // Post-reset defaults
   // ========================================================================
   localparam logic [7:0] PORT_LATCH_RST = 8'hff;
   localparam logic [15:0] FETCH_ADDR_RST = 16'h0000;
   localparam logic [3:0] WDOG_DIV_RST = 4'hc;

   // Synchronised pin inputs: pin, supply ok, comparator, clock tap
   localparam int SYNC_W = 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'h5;

   typedef enum logic [1:0] {
      ST_POR_WAIT,
      ST_POR_DELAY,
      ST_HOLD,
      ST_RUN
   } rsc_state_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rsc_reg_req_type;

   typedef struct packed {
      logic core_hold;
      logic ram_wr_block;
      logic sp_load;
      logic port_od;
      logic pullup_en;
      logic [7:0] port_latch;
      logic dflt_load;
      logic clk_int_osc;
      logic wdog_en;
      logic [3:0] wdog_div;
      logic [15:0] fetch_addr;
   } rsc_core_ctrl_type;

   // Core side while this block is itself reset: held, ports safe
   localparam rsc_core_ctrl_type CORE_CTRL_RST = '{
      core_hold: 1'b1,
      ram_wr_block: 1'b1,
      sp_load: 1'b1,
      port_od: 1'b1,
      pullup_en: 1'b1,
      port_latch: PORT_LATCH_RST,
      dflt_load: 1'b0,
      clk_int_osc: 1'b0,
      wdog_en: 1'b0,
      wdog_div: WDOG_DIV_RST,
      fetch_addr: FETCH_ADDR_RST
   };

endpackage : rsc_pkg

// [design/rsc_sync.sv]
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end
      else if (ce_i)
      begin
         meta_ff <= d_i;
         q_ff <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule : rsc_sync
`default_nettype wire

// [design/rsc_clk_monitor.sv]
// Missing clock one-shot: times out when the watched level stops moving
`timescale 1ns/1ps
`default_nettype none
module rsc_clk_monitor #(
   parameter int TIMEOUT_CYC = rsc_pkg::CLK_LOSS_TIMEOUT_CYC,
   parameter int CNT_W = rsc_pkg::CNT_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Control and watched level
   input wire logic en_i,
   input wire logic lvl_i,
   output logic timeout_o
);

   logic last_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic to_ff;
   wire moved = lvl_i != last_ff;
   wire expired = cnt_ff == CNT_W'(TIMEOUT_CYC - 1);

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         last_ff <= 1'b0;
         cnt_ff <= '0;
         to_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         last_ff <= lvl_i;
         // Restart on each edge; disabled detector stays cleared
         if (!en_i || moved || expired)
            cnt_ff <= '0;
         else
            cnt_ff <= cnt_ff + 1'b1;
         to_ff <= en_i && !moved && expired;
      end
   end

   assign timeout_o = to_ff;

endmodule : rsc_clk_monitor
`default_nettype wire

// [design/rsc_reset_controller.sv]
// Reset source controller: combines sources, sequences reset, keeps flags
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_controller #(
   parameter int POR_DELAY_CYC = rsc_pkg::POR_DELAY_CYC,
   parameter int CLK_LOSS_TIMEOUT_CYC = rsc_pkg::CLK_LOSS_TIMEOUT_CYC,
   parameter int HOLD_MIN_CYC = rsc_pkg::HOLD_MIN_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Register port
   input wire rsc_pkg::rsc_reg_req_type req_i,
   output logic [7:0] rdata_o,
   // Reset pin, open drain
   input wire logic rst_pin_n_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   // Analog and clock sources
   input wire logic supply_ok_i,
   input wire logic cmp_out_i,
   input wire logic sysclk_tap_i,
   // Watchdog expiry from the counter array, same clock
   input wire logic wdog_expire_i,
   // Core side
   output rsc_pkg::rsc_core_ctrl_type core_ctrl_o
);

   // =========================================================================
   // Input synchronisers and missing clock detector
   // =========================================================================
   logic [rsc_pkg::SYNC_W-1:0] sync_q;
   logic clk_loss_timeout;
   logic clk_loss_en_ff;

   rsc_sync #(
      .W(rsc_pkg::SYNC_W),
      .RST_VAL(rsc_pkg::SYNC_RST)
   ) u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .d_i({sysclk_tap_i, cmp_out_i, supply_ok_i, rst_pin_n_i}),
      .q_o(sync_q)
   );

   wire pin_n_s = sync_q[0];
   wire supply_ok_s = sync_q[1];
   wire cmp_s = sync_q[2];

   rsc_clk_monitor #(
      .TIMEOUT_CYC(CLK_LOSS_TIMEOUT_CYC),
      .CNT_W(rsc_pkg::CNT_W)
   ) u_clk_loss (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .en_i(clk_loss_en_ff),
      .lvl_i(sync_q[3]),
      .timeout_o(clk_loss_timeout)
   );

   // =========================================================================
   // State
   // =========================================================================
   rsc_pkg::rsc_state_type st_ff;
   rsc_pkg::rsc_state_type nxt_st;
   logic [rsc_pkg::CNT_W-1:0] cnt_ff;
   logic [rsc_pkg::CNT_W-1:0] nxt_cnt;
   logic [rsc_pkg::NUM_SRC-1:0] cause_ff;
   logic [rsc_pkg::NUM_SRC-1:0] nxt_cause;
   logic [rsc_pkg::NUM_FLAGS-1:0] flags_ff;
   logic [rsc_pkg::NUM_FLAGS-1:0] nxt_flags;
   logic mon_en_ff;
   logic mon_sel_ff;
   logic cmp_en_ff;
   logic drive_ff;
   logic nxt_drive;
   logic pin_oe_ff;
   logic pin_o_ff;
   logic [7:0] rdata_ff;
   rsc_pkg::rsc_core_ctrl_type ctrl_ff;
   rsc_pkg::rsc_core_ctrl_type nxt_ctrl;

   // =========================================================================
   // Register decode
   // =========================================================================
   wire running = st_ff == rsc_pkg::ST_RUN;
   wire hit_src = req_i.addr == rsc_pkg::REG_RESET_SOURCE_ADDR;
   wire hit_mon = req_i.addr == rsc_pkg::REG_SUPPLY_MON_ADDR;
   // Core is halted in reset, so writes only land while running
   wire wr_src = req_i.wr && hit_src && running;
   wire wr_mon = req_i.wr && hit_mon && running;
   wire sw_req = wr_src && req_i.wdata[rsc_pkg::BIT_SW];
   wire [7:0] src_rd = {2'b00, flags_ff};
   wire [7:0] mon_rd = {mon_en_ff, 7'h00};
   wire [7:0] rd_mux;

   assign rd_mux = !req_i.rd ? rsc_pkg::RDATA_RST :
                   hit_src ? src_rd :
                   hit_mon ? mon_rd : rsc_pkg::RDATA_RST;

   // =========================================================================
   // Source combining
   // =========================================================================
   // Pin reads back low while this block pulls it, so ignore it then
   wire pin_act = !pin_n_s && !drive_ff;
   wire mon_act = mon_en_ff && mon_sel_ff && !supply_ok_s;
   wire cmp_act = cmp_en_ff && !cmp_s;
   logic [rsc_pkg::NUM_SRC-1:0] src_act;

   always_comb
   begin
      src_act = '0;
      src_act[rsc_pkg::BIT_PIN] = pin_act;
      src_act[rsc_pkg::BIT_CLK_LOSS] = clk_loss_timeout;
      src_act[rsc_pkg::BIT_WDOG] = wdog_expire_i;
      src_act[rsc_pkg::BIT_SW] = sw_req;
      src_act[rsc_pkg::BIT_CMP] = cmp_act;
      src_act[rsc_pkg::SRC_MON] = mon_act;
   end

   wire any_src = |src_act;
   wire level_act = pin_act || mon_act || cmp_act;
   wire hold_done = cnt_ff >= rsc_pkg::CNT_W'(HOLD_MIN_CYC - 1);
   wire por_done = cnt_ff == rsc_pkg::CNT_W'(POR_DELAY_CYC - 1);

   // =========================================================================
   // Sequencer
   // =========================================================================
   always_comb
   begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff + 1'b1;
      nxt_cause = cause_ff;
      nxt_drive = drive_ff;
      nxt_flags = flags_ff;
      case (st_ff)
         rsc_pkg::ST_POR_WAIT:
         begin
            nxt_cnt = '0;
            if (supply_ok_s)
               nxt_st = rsc_pkg::ST_POR_DELAY;
         end
         rsc_pkg::ST_POR_DELAY:
         begin
            if (!supply_ok_s)
            begin
               nxt_st = rsc_pkg::ST_POR_WAIT;
               nxt_cnt = '0;
            end
            else if (por_done)
            begin
               nxt_st = rsc_pkg::ST_RUN;
               // Other flags undefined after power-on; shown as zero
               nxt_flags = '0;
               nxt_flags[rsc_pkg::BIT_POR] = 1'b1;
            end
         end
         rsc_pkg::ST_HOLD:
         begin
            nxt_cause = cause_ff | src_act;
            // Monitor release skips the power-on delay
            if (!level_act && hold_done)
            begin
               nxt_st = rsc_pkg::ST_RUN;
               // Power-on flag cleared by every other reset
               nxt_flags = nxt_cause[rsc_pkg::NUM_FLAGS-1:0];
            end
         end
         default:
         begin
            nxt_cnt = '0;
            // Own drive echoes low through the sync; limitation: an
            // outside hold of the pin across release is not seen
            if (pin_n_s)
               nxt_drive = 1'b0;
            if (any_src)
            begin
               nxt_st = rsc_pkg::ST_HOLD;
               nxt_cause = src_act;
               nxt_drive = mon_act;
            end
         end
      endcase
   end

   wire nxt_in_rst = nxt_st != rsc_pkg::ST_RUN;
   wire exit_now = !running && !nxt_in_rst;

   // =========================================================================
   // Core-side defaults
   // =========================================================================
   always_comb
   begin
      nxt_ctrl.core_hold = nxt_in_rst;
      nxt_ctrl.ram_wr_block = nxt_in_rst;
      nxt_ctrl.sp_load = nxt_in_rst;
      nxt_ctrl.port_od = nxt_in_rst;
      nxt_ctrl.pullup_en = 1'b1;
      nxt_ctrl.port_latch = rsc_pkg::PORT_LATCH_RST;
      nxt_ctrl.dflt_load = exit_now;
      nxt_ctrl.clk_int_osc = exit_now;
      nxt_ctrl.wdog_en = exit_now;
      nxt_ctrl.wdog_div = rsc_pkg::WDOG_DIV_RST;
      nxt_ctrl.fetch_addr = rsc_pkg::FETCH_ADDR_RST;
   end

   // =========================================================================
   // Flip-flops
   // =========================================================================
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         st_ff <= rsc_pkg::ST_POR_WAIT;
         cnt_ff <= '0;
         cause_ff <= '0;
         flags_ff <= '0;
         drive_ff <= 1'b1;
      end
      else if (ce_i)
      begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         cause_ff <= nxt_cause;
         flags_ff <= nxt_flags;
         drive_ff <= nxt_drive;
      end
   end

   // Configuration bits; power-on is the only reset that touches monitor
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         mon_en_ff <= 1'b1;
         mon_sel_ff <= 1'b1;
         clk_loss_en_ff <= 1'b0;
         cmp_en_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wr_mon)
            mon_en_ff <= req_i.wdata[rsc_pkg::BIT_MON_EN];
         if (wr_src)
            mon_sel_ff <= req_i.wdata[rsc_pkg::BIT_POR];
         // Kept through the hold so a low comparator stretches it
         if (exit_now)
         begin
            clk_loss_en_ff <= 1'b0;
            cmp_en_ff <= 1'b0;
         end
         else if (wr_src)
         begin
            clk_loss_en_ff <= req_i.wdata[rsc_pkg::BIT_CLK_LOSS];
            cmp_en_ff <= req_i.wdata[rsc_pkg::BIT_CMP];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pin_oe_ff <= 1'b1;
         pin_o_ff <= 1'b0;
         rdata_ff <= rsc_pkg::RDATA_RST;
         ctrl_ff <= rsc_pkg::CORE_CTRL_RST;
      end
      else if (ce_i)
      begin
         pin_oe_ff <= nxt_in_rst && nxt_drive;
         pin_o_ff <= 1'b0;
         rdata_ff <= rd_mux;
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign rst_pin_oe_o = pin_oe_ff;
   assign rst_pin_o = pin_o_ff;
   assign rdata_o = rdata_ff;
   assign core_ctrl_o = ctrl_ff;

   // =========================================================================
   // Assertions
   // =========================================================================
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   property p_pin_drive;
      rst_pin_oe_o |-> (!running && drive_ff);
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("reset pin driven outside a driving reset");

   property p_internal_quiet;
      (ce_i && running && !mon_act && any_src) |=> !rst_pin_oe_o;
   endproperty
   a_internal_quiet: assert property (p_internal_quiet)
      else $error("internal reset source drove the pin");

   property p_monitor_reset;
      (ce_i && running && mon_act) |=> (core_ctrl_o.core_hold && rst_pin_oe_o);
   endproperty
   a_monitor_reset: assert property (p_monitor_reset)
      else $error("supply low did not reset with pin driven");

   property p_por_flag;
      (ce_i && exit_now && st_ff == rsc_pkg::ST_POR_DELAY)
         |=> (flags_ff == 6'h02);
   endproperty
   a_por_flag: assert property (p_por_flag)
      else $error("power-on exit flags wrong");

   property p_por_clear;
      (ce_i && exit_now && st_ff == rsc_pkg::ST_HOLD)
         |=> !flags_ff[rsc_pkg::BIT_POR];
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("power-on flag survived another reset");

   property p_por_delay;
      (ce_i && st_ff == rsc_pkg::ST_POR_DELAY && !nxt_in_rst)
         |-> (cnt_ff == rsc_pkg::CNT_W'(POR_DELAY_CYC - 1));
   endproperty
   a_por_delay: assert property (p_por_delay)
      else $error("power-on released before delay elapsed");

   property p_pin_flag;
      (ce_i && exit_now && st_ff == rsc_pkg::ST_HOLD
         && cause_ff[rsc_pkg::BIT_PIN]) |=> flags_ff[rsc_pkg::BIT_PIN];
   endproperty
   a_pin_flag: assert property (p_pin_flag)
      else $error("pin flag not set after pin reset");

   property p_wdog_reset;
      (ce_i && running && wdog_expire_i)
         |=> (core_ctrl_o.core_hold && cause_ff[rsc_pkg::BIT_WDOG]);
   endproperty
   a_wdog_reset: assert property (p_wdog_reset)
      else $error("watchdog expiry did not reset");

   property p_sw_reset;
      (ce_i && sw_req) |=> ##[0:8] !running ##0 cause_ff[rsc_pkg::BIT_SW];
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("software reset request ignored");

   property p_cmp_reset;
      (ce_i && running && cmp_act) |=> core_ctrl_o.core_hold;
   endproperty
   a_cmp_reset: assert property (p_cmp_reset)
      else $error("comparator low did not reset");

   property p_clk_loss_reset;
      (ce_i && running && clk_loss_timeout) |=> !running;
   endproperty
   a_clk_loss_reset: assert property (p_clk_loss_reset)
      else $error("clock loss did not reset");

   property p_defaults;
      (ce_i && exit_now) |=> (core_ctrl_o.dflt_load && core_ctrl_o.wdog_en
         && core_ctrl_o.wdog_div == rsc_pkg::WDOG_DIV_RST
         && core_ctrl_o.fetch_addr == rsc_pkg::FETCH_ADDR_RST);
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults not loaded on reset exit");

   property p_ports;
      core_ctrl_o.core_hold |-> (core_ctrl_o.port_od
         && core_ctrl_o.port_latch == rsc_pkg::PORT_LATCH_RST
         && core_ctrl_o.pullup_en && core_ctrl_o.ram_wr_block);
   endproperty
   a_ports: assert property (p_ports)
      else $error("port or memory state wrong in reset");

   property p_mon_kept;
      (st_ff == rsc_pkg::ST_HOLD) |=> $stable(mon_en_ff);
   endproperty
   a_mon_kept: assert property (p_mon_kept)
      else $error("monitor enable changed by non power-on reset");

   c_por_exit: cover property (st_ff == rsc_pkg::ST_POR_DELAY ##1 running);
   c_pin_reset: cover property (running && pin_act ##[1:20] running);
   c_sw_reset: cover property (sw_req ##[1:20] exit_now);
   c_mon_reset: cover property (running && mon_act);

endmodule : rsc_reset_controller
`default_nettype wire

// [tb/rsc_far_side.sv]
// Far-side model: reset pin pull-up, supply, comparator and clock tap
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
   // Clock
   input wire logic clk_i,
   // Commands from the bench
   input wire logic pin_low_i,
   input wire logic supply_i,
   input wire logic cmp_i,
   input wire logic tap_run_i,
   // Device pin driver
   input wire logic rst_pin_i,
   input wire logic rst_pin_oe_i,
   // Levels seen by the device
   output logic rst_pin_n_o,
   output logic supply_ok_o,
   output logic cmp_out_o,
   output var logic sysclk_tap_o
);
   // ========================================
   // Wired pin with pull-up: any party may pull it low
   assign rst_pin_n_o = !pin_low_i && !(rst_pin_oe_i && !rst_pin_i);
   assign supply_ok_o = supply_i;
   assign cmp_out_o = cmp_i;
   // A dead clock parks its tap high
   initial sysclk_tap_o = 1'b0;
   always @(posedge clk_i)
   begin
      sysclk_tap_o <= tap_run_i ? !sysclk_tap_o : 1'b1;
   end
endmodule : rsc_far_side
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ========================================
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   rsc_pkg::rsc_reg_req_type req = '0;
   logic [7:0] rdata;
   logic pin_low = 1'b0;
   logic supply = 1'b0;
   logic cmp = 1'b1;
   logic tap_run = 1'b1;
   logic wdog = 1'b0;
   logic ce = 1'b1;
   logic pin_o, pin_oe, pin_n, sok, cmpo, tap;
   rsc_pkg::rsc_core_ctrl_type ctrl;
   logic [7:0] exp_q[$];
   logic rd_d = 1'b0;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int n, k;
   integer seed = 32;
   logic [7:0] a;

   always #5 clk_i = ~clk_i;

   // Delays shortened so the whole run stays small
   rsc_reset_controller #(
      .POR_DELAY_CYC(20),
      .CLK_LOSS_TIMEOUT_CYC(16),
      .HOLD_MIN_CYC(4)
   ) i_rsc_reset_controller (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
      .req_i(req), .rdata_o(rdata),
      .rst_pin_n_i(pin_n), .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe),
      .supply_ok_i(sok), .cmp_out_i(cmpo), .sysclk_tap_i(tap),
      .wdog_expire_i(wdog), .core_ctrl_o(ctrl)
   );

   rsc_far_side i_rsc_far_side (
      .clk_i(clk_i), .pin_low_i(pin_low), .supply_i(supply),
      .cmp_i(cmp), .tap_run_i(tap_run), .rst_pin_i(pin_o),
      .rst_pin_oe_i(pin_oe), .rst_pin_n_o(pin_n),
      .supply_ok_o(sok), .cmp_out_o(cmpo), .sysclk_tap_o(tap)
   );

   // ========================================
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task end_of_test();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_i)
   begin
      if (rd_d)
         chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
      rd_d <= req.rd;
      cyc++;
      if (cyc == 4000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   task wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      req.addr <= ad;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk_i);
      req.wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge clk_i);
      exp_q.push_back(e);
      req.addr <= ad;
      req.rd <= 1'b1;
      @(posedge clk_i);
      req.rd <= 1'b0;
   endtask : rd

   task wait_hold(input logic oe_e);
      n = 0;
      @(negedge clk_i);
      while (ctrl.core_hold !== 1'b1 && n < 40)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(ctrl.core_hold, 16'h1);
      chk(pin_oe, oe_e);
      chk(pin_o, 16'h0);
      chk({ctrl.ram_wr_block, ctrl.sp_load, ctrl.port_od}, 16'h7);
      chk({ctrl.pullup_en, ctrl.port_latch}, 16'h1ff);
   endtask : wait_hold

   task wait_rel(input int lo, input int hi);
      logic seen;
      n = 0;
      while (ctrl.core_hold === 1'b1 && n < 100)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(n >= lo && n <= hi, 16'h1);
      seen = ctrl.dflt_load & ctrl.clk_int_osc & ctrl.wdog_en;
      @(negedge clk_i);
      seen |= ctrl.dflt_load & ctrl.clk_int_osc & ctrl.wdog_en;
      chk(seen, 16'h1);
      chk(ctrl.fetch_addr, 16'h0000);
      chk(ctrl.wdog_div, 16'hc);
   endtask : wait_rel

   // ========================================
   initial
   begin
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk({ctrl.core_hold, ctrl.pullup_en, pin_oe}, 16'h7);
      @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (10) @(negedge clk_i);
      wait_hold(1'b1);
      @(posedge clk_i);
      supply <= 1'b1;
      wait_rel(20, 32);
      rd(8'hef, 8'h02);
      rd(8'hfe, 8'h80);
      a = 8'($random(seed));
      if (a == 8'hef || a == 8'hfe)
         a = 8'h00;
      rd(a, 8'h00);
      $display("test power_on done");
      @(posedge clk_i);
      pin_low <= 1'b1;
      wait_hold(1'b0);
      @(posedge clk_i);
      pin_low <= 1'b0;
      wait_rel(1, 12);
      rd(8'hef, 8'h01);
      $display("test pin done");
      wr(8'hfe, 8'h00);
      wr(8'hef, 8'h10);
      wait_hold(1'b0);
      wait_rel(1, 12);
      rd(8'hef, 8'h10);
      rd(8'hfe, 8'h00);
      wr(8'hfe, 8'h80);
      repeat (20) @(posedge clk_i);
      wr(8'hef, 8'h02);
      $display("test software done");
      @(posedge clk_i);
      wdog <= 1'b1;
      @(posedge clk_i);
      wdog <= 1'b0;
      wait_hold(1'b0);
      wait_rel(1, 12);
      rd(8'hef, 8'h08);
      $display("test watchdog done");
      // Comparator already settled high before it is armed
      wr(8'hef, 8'h22);
      k = 3 + {$random(seed)} % 4;
      @(posedge clk_i);
      cmp <= 1'b0;
      wait_hold(1'b0);
      repeat (k) @(posedge clk_i);
      cmp <= 1'b1;
      wait_rel(1, 16);
      rd(8'hef, 8'h20);
      $display("test comparator done");
      @(posedge clk_i);
      tap_run <= 1'b0;
      repeat (40) @(negedge clk_i);
      chk(ctrl.core_hold, 16'h0);
      @(posedge clk_i);
      tap_run <= 1'b1;
      wr(8'hef, 8'h06);
      @(posedge clk_i);
      tap_run <= 1'b0;
      wait_hold(1'b0);
      @(posedge clk_i);
      tap_run <= 1'b1;
      wait_rel(1, 12);
      rd(8'hef, 8'h04);
      $display("test clock_loss done");
      @(posedge clk_i);
      supply <= 1'b0;
      wait_hold(1'b1);
      @(posedge clk_i);
      supply <= 1'b1;
      wait_rel(1, 12);
      rd(8'hef, 8'h00);
      rd(8'hfe, 8'h80);
      $display("test supply_monitor done");
      // Frozen block must not take a pin pulse
      @(posedge clk_i);
      ce <= 1'b0;
      pin_low <= 1'b1;
      repeat (6) @(negedge clk_i);
      chk({ctrl.core_hold, pin_oe}, 16'h0);
      @(posedge clk_i);
      pin_low <= 1'b0;
      @(posedge clk_i);
      ce <= 1'b1;
      repeat (6) @(negedge clk_i);
      chk(ctrl.core_hold, 16'h0);
      $display("test clock_enable done");
      repeat (3) @(posedge clk_i);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
